// ==== hw/bcr_pkg.sv ====
// Package with offsets, field positions and reset values of the bridge command register.
`default_nettype none

package bcr_pkg;

	typedef logic [7:0] bcr_addr_t;
	typedef logic [15:0] bcr_cmd_t;

	// Configuration offset of the dword holding command and status.
	localparam bcr_addr_t BCR_CMD_OFF    = 8'h04;

	// Command field positions.
	localparam int        BCR_IO_EN      = 0;
	localparam int        BCR_MEM_EN     = 1;
	localparam int        BCR_MASTER_EN  = 2;
	localparam int        BCR_SPECIAL    = 3;
	localparam int        BCR_MWI_EN     = 4;
	localparam int        BCR_PALETTE    = 5;
	localparam int        BCR_PERR_EN    = 6;
	localparam int        BCR_WAIT_CTL   = 7;
	localparam int        BCR_SERR_EN    = 8;
	localparam int        BCR_FAST_B2B   = 9;
	localparam int        BCR_INT_DIS    = 10;

	// Status flag position inside the dword.
	localparam int        BCR_MDPE_BIT   = 24;

	// Writable command bits: 0, 1, 2, 5, 6, 8 and 10.
	localparam bcr_cmd_t  BCR_CMD_WMASK  = 16'h0567;
	localparam bcr_cmd_t  BCR_CMD_RESET  = 16'h0000;
	localparam logic      BCR_MDPE_RESET = 1'h0;

endpackage

`default_nettype wire

// ==== hw/bcr_cmd_if.sv ====
// Interface between the command register and its transaction gate.
`timescale 1ns/100ps
`default_nettype none

interface bcr_cmd_if;

	// Enables taken from the command register.
	logic io_en;
	logic mem_en;
	logic master_en;
	logic serr_en;

	// Requests from the transaction layer.
	logic io_req;
	logic mem_rd_req;
	logic sec_req;
	logic mwi_fwd_req;
	logic err_req;

	// Registered decisions.
	logic io_acc;
	logic mem_acc;
	logic sec_acc;
	logic master;
	logic mwi_fwd;
	logic err_send;

	modport regs
	(
		output io_en, mem_en, master_en, serr_en,
		output io_req, mem_rd_req, sec_req, mwi_fwd_req, err_req,
		input  io_acc, mem_acc, sec_acc, master, mwi_fwd, err_send
	);

	modport gate
	(
		input  io_en, mem_en, master_en, serr_en,
		input  io_req, mem_rd_req, sec_req, mwi_fwd_req, err_req,
		output io_acc, mem_acc, sec_acc, master, mwi_fwd, err_send
	);

endinterface

`default_nettype wire

// ==== hw/bcr_gate.sv ====
// Transaction gate that applies the command enables to incoming requests.
`timescale 1ns/100ps
`default_nettype none

module bcr_gate
(
	// Clock, reset and enable.
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	// Register side.
	bcr_cmd_if.gate   g
);

	typedef struct packed
	{
		logic io_acc;
		logic mem_acc;
		logic sec_acc;
		logic master;
		logic mwi_fwd;
		logic err_send;
	} bcr_gate_s;

	bcr_gate_s s_q;
	bcr_gate_s s_d;

	////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		s_d          = s_q;
		s_d.io_acc   = g.io_req & g.io_en;
		s_d.mem_acc  = g.mem_rd_req & g.mem_en;
		s_d.sec_acc  = g.sec_req & g.master_en;
		s_d.master   = g.master_en;
		// Write-and-invalidate only passes through for another master.
		s_d.mwi_fwd  = g.mwi_fwd_req & g.master_en;
		s_d.err_send = g.err_req & g.serr_en;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			s_q <= '0;
		else if (i_ce)
			s_q <= s_d;
	end

	assign g.io_acc   = s_q.io_acc;
	assign g.mem_acc  = s_q.mem_acc;
	assign g.sec_acc  = s_q.sec_acc;
	assign g.master   = s_q.master;
	assign g.mwi_fwd  = s_q.mwi_fwd;
	assign g.err_send = s_q.err_send;

endmodule // bcr_gate

`default_nettype wire

// ==== hw/bcr_cmd_reg.sv ====
// Bridge command register with its master data parity error status flag.
//
// Notes on behaviour
// - I/O enable gates primary I/O responses.
// - Memory enable gates primary memory read acceptance.
// - Master clear: no primary mastering, no secondary response.
// - Master set: forward secondary traffic onto primary.
// - Special cycle bit reads zero; never responds.
// - Invalidate bit reads zero; only forwarded through.
// - Palette, wait, fast, interrupt bits do nothing.
// - Parity response bit lets errors set status flag.
// - Error messages sent only while report enable set.
// - Status flag set by poison only when enabled.
`timescale 1ns/100ps
`default_nettype none

module bcr_cmd_reg
(
	// Clock, reset and enable.
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_ce,
	// Configuration access from the primary link.
	input  wire logic              i_cfg_wr,
	input  wire logic              i_cfg_rd,
	input  wire bcr_pkg::bcr_addr_t i_cfg_addr,
	input  wire logic [31:0]       i_cfg_wdata,
	input  wire logic [3:0]        i_cfg_be,
	output logic [31:0]            o_cfg_rdata,
	output logic                   o_cfg_rvalid,
	// Transaction requests.
	input  wire logic              i_pri_io_req,
	input  wire logic              i_pri_mem_rd_req,
	input  wire logic              i_sec_req,
	input  wire logic              i_mwi_fwd_req,
	input  wire logic              i_err_req,
	// Error events on the primary side.
	input  wire logic              i_poison_cpl_rx,
	input  wire logic              i_poison_wr_tx,
	// Decisions and status.
	output logic                   o_pri_io_accept,
	output logic                   o_pri_mem_rd_accept,
	output logic                   o_sec_accept,
	output logic                   o_pri_master_en,
	output logic                   o_mwi_forward,
	output logic                   o_err_msg_send,
	output logic                   o_mdpe
);

	import bcr_pkg::*;

	typedef struct packed
	{
		bcr_cmd_t    cmd;
		logic        mdpe;
		logic [31:0] rdata;
		logic        rvalid;
	} bcr_reg_s;

	bcr_reg_s s_q;
	bcr_reg_s s_d;

	bcr_cmd_if cif ();

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// True when an access targets the command and status dword.
	function automatic logic dword_hit(input bcr_addr_t addr);
		dword_hit = (addr[7:2] == BCR_CMD_OFF[7:2]);
	endfunction

	// Merges write data into the command field under byte enables.
	function automatic bcr_cmd_t cmd_merge(input bcr_cmd_t old,
		input logic [15:0] wd, input logic [1:0] be);
		bcr_cmd_t lane;
		lane      = {{8{be[1]}}, {8{be[0]}}};
		cmd_merge = ((old & ~lane) | (wd & lane)) & BCR_CMD_WMASK;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register update.

	logic wr_hit;
	logic rd_hit;
	logic perr_event;
	logic mdpe_clr;

	assign wr_hit     = i_cfg_wr & dword_hit(i_cfg_addr);
	assign rd_hit     = i_cfg_rd & dword_hit(i_cfg_addr);
	assign perr_event = s_q.cmd[BCR_PERR_EN]
		& (i_poison_cpl_rx | i_poison_wr_tx);
	assign mdpe_clr   = wr_hit & i_cfg_be[3]
		& i_cfg_wdata[BCR_MDPE_BIT];

	always_comb
	begin
		s_d        = s_q;
		s_d.rvalid = i_cfg_rd;
		s_d.rdata  = '0;
		if (wr_hit)
		begin
			// Read-only and reserved bits stay zero.
			s_d.cmd = cmd_merge(s_q.cmd, i_cfg_wdata[15:0],
				i_cfg_be[1:0]);
		end
		// A poison event in the clearing cycle keeps the flag set.
		if (perr_event)
			s_d.mdpe = 1'b1;
		else if (mdpe_clr)
			s_d.mdpe = 1'b0;
		if (rd_hit)
		begin
			s_d.rdata[15:0]         = s_q.cmd;
			s_d.rdata[BCR_MDPE_BIT] = s_q.mdpe;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s_q.cmd    <= BCR_CMD_RESET;
			s_q.mdpe   <= BCR_MDPE_RESET;
			s_q.rdata  <= '0;
			s_q.rvalid <= 1'b0;
		end
		else if (i_ce)
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Transaction gate. Palette, interrupt disable and the read-only
	// controls are stored or read back but steer nothing.

	assign cif.io_en       = s_q.cmd[BCR_IO_EN];
	assign cif.mem_en      = s_q.cmd[BCR_MEM_EN];
	assign cif.master_en   = s_q.cmd[BCR_MASTER_EN];
	assign cif.serr_en     = s_q.cmd[BCR_SERR_EN];
	assign cif.io_req      = i_pri_io_req;
	assign cif.mem_rd_req  = i_pri_mem_rd_req;
	assign cif.sec_req     = i_sec_req;
	assign cif.mwi_fwd_req = i_mwi_fwd_req;
	assign cif.err_req     = i_err_req;

	bcr_gate u_gate
	(
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.g     (cif.gate)
	);

	assign o_cfg_rdata         = s_q.rdata;
	assign o_cfg_rvalid        = s_q.rvalid;
	assign o_mdpe              = s_q.mdpe;
	assign o_pri_io_accept     = cif.io_acc;
	assign o_pri_mem_rd_accept = cif.mem_acc;
	assign o_sec_accept        = cif.sec_acc;
	assign o_pri_master_en     = cif.master;
	assign o_mwi_forward       = cif.mwi_fwd;
	assign o_err_msg_send      = cif.err_send;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_io_gate_off: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_pri_io_req && !s_q.cmd[BCR_IO_EN] |=> !o_pri_io_accept)
		else $error("I/O request accepted while I/O enable clear.");

	a_io_gate_on: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_pri_io_req && s_q.cmd[BCR_IO_EN] |=> o_pri_io_accept)
		else $error("I/O request dropped while I/O enable set.");

	a_mem_rd_gate: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce |=> o_pri_mem_rd_accept ==
		$past(i_pri_mem_rd_req && s_q.cmd[BCR_MEM_EN]))
		else $error("Memory read acceptance disagrees with enable.");

	a_master_off: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && !s_q.cmd[BCR_MASTER_EN]
		|=> !o_sec_accept && !o_pri_master_en && !o_mwi_forward)
		else $error("Bridge mastered while master enable clear.");

	a_master_on: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && s_q.cmd[BCR_MASTER_EN] && i_sec_req
		|=> o_sec_accept && o_pri_master_en)
		else $error("Forwarded request not mastered while enabled.");

	a_ro_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_cfg_rdata[BCR_SPECIAL] && !o_cfg_rdata[BCR_MWI_EN]
		&& !o_cfg_rdata[BCR_WAIT_CTL] && !o_cfg_rdata[BCR_FAST_B2B])
		else $error("Read-only command bit read as one.");

	a_rw_store: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && wr_hit && (i_cfg_be[1:0] == 2'h3)
		|=> s_q.cmd == ($past(i_cfg_wdata[15:0]) & BCR_CMD_WMASK))
		else $error("Command write stored wrong bits.");

	a_mdpe_cause: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_mdpe) |-> $past(s_q.cmd[BCR_PERR_EN]
		&& (i_poison_cpl_rx || i_poison_wr_tx)))
		else $error("Parity status set without enabled poison event.");

	a_mdpe_set: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && perr_event |=> o_mdpe ##1 (o_mdpe
		|| $past(i_ce && mdpe_clr && !perr_event)))
		else $error("Enabled poison event did not set parity status.");

	a_err_msg: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && !(s_q.cmd[BCR_SERR_EN] && i_err_req) |=> !o_err_msg_send)
		else $error("Error message sent while reporting disabled.");

	a_reset_val: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(i_rst) |-> s_q.cmd == BCR_CMD_RESET && !o_mdpe
		&& !o_cfg_rvalid && !o_err_msg_send)
		else $error("State not cleared by reset.");

	a_rsvd_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		o_cfg_rdata[15:11] == 5'h00 && o_cfg_rdata[23:16] == 8'h00
		&& o_cfg_rdata[31:25] == 7'h00)
		else $error("Reserved bits read as nonzero.");

	a_rd_answer: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && i_cfg_rd && !dword_hit(i_cfg_addr)
		|=> o_cfg_rvalid && o_cfg_rdata == 32'h0000_0000)
		else $error("Unmapped read did not answer zero.");

endmodule // bcr_cmd_reg

`default_nettype wire

// ==== tb/bcr_rc_model.sv ====
// Root complex model that issues configuration accesses to the bridge.
`timescale 1ns/100ps
`default_nettype none

module bcr_rc_model
(
	// Clock and read answer.
	input  wire logic          i_clk,
	input  wire logic [31:0]   i_cfg_rdata,
	input  wire logic          i_cfg_rvalid,
	// Configuration requests.
	output logic               o_cfg_wr,
	output logic               o_cfg_rd,
	output bcr_pkg::bcr_addr_t o_cfg_addr,
	output logic [31:0]        o_cfg_wdata,
	output logic [3:0]         o_cfg_be
);
	import bcr_pkg::*;

	initial
	begin
		o_cfg_wr = 1'h0;
		o_cfg_rd = 1'h0;
		o_cfg_addr = 8'h00;
		o_cfg_wdata = 32'h0;
		o_cfg_be = 4'h0;
	end

	// A write is a one-cycle strobe; released data shows its inverse.
	task automatic cfg_write(input bcr_addr_t a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge i_clk);
		#1;
		o_cfg_wr = 1'h1;
		o_cfg_addr = a;
		o_cfg_wdata = d;
		o_cfg_be = be;
		@(posedge i_clk);
		#1;
		o_cfg_wr = 1'h0;
		o_cfg_wdata = ~d;
	endtask

	// A read is answered exactly one edge after it is taken.
	task automatic cfg_read(input bcr_addr_t a, output logic [31:0] d,
		output logic v);
		@(posedge i_clk);
		#1;
		o_cfg_rd = 1'h1;
		o_cfg_addr = a;
		@(posedge i_clk);
		#1;
		o_cfg_rd = 1'h0;
		d = i_cfg_rdata;
		v = i_cfg_rvalid;
	endtask

endmodule // bcr_rc_model

`default_nettype wire

// ==== tb/bcr_cmd_reg_tb_top.sv ====
// Self-checking testbench of the bridge command register.
`timescale 1ns/100ps
`default_nettype none

module bcr_cmd_reg_tb_top;
	import bcr_pkg::*;

	logic        clk, rst, ce, wr, rd, rvalid, v;
	logic        io_rq, mem_rq, sec_rq, mwi_rq, err_rq, pois_c, pois_w;
	logic        io_ac, mem_ac, sec_ac, mst, mwi, err_s, mdpe;
	bcr_addr_t   addr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  be;
	int          err_total = 0;
	int          checked = 0;
	int          cyc = 0;
	int          sel [4] = '{0, 1, 2, 8};

	bcr_cmd_reg dut
	(
		.i_clk(clk), .i_rst(rst), .i_ce(ce),
		.i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
		.i_cfg_wdata(wdata), .i_cfg_be(be),
		.o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
		.i_pri_io_req(io_rq), .i_pri_mem_rd_req(mem_rq),
		.i_sec_req(sec_rq), .i_mwi_fwd_req(mwi_rq), .i_err_req(err_rq),
		.i_poison_cpl_rx(pois_c), .i_poison_wr_tx(pois_w),
		.o_pri_io_accept(io_ac), .o_pri_mem_rd_accept(mem_ac),
		.o_sec_accept(sec_ac), .o_pri_master_en(mst),
		.o_mwi_forward(mwi), .o_err_msg_send(err_s), .o_mdpe(mdpe)
	);

	bcr_rc_model rc
	(
		.i_clk(clk), .i_cfg_rdata(rdata), .i_cfg_rvalid(rvalid),
		.o_cfg_wr(wr), .o_cfg_rd(rd), .o_cfg_addr(addr),
		.o_cfg_wdata(wdata), .o_cfg_be(be)
	);

	initial
	begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Pulses every request once and checks the decisions one edge later.
	task automatic pulse_reqs(input logic [15:0] c);
		@(posedge clk);
		#1;
		{io_rq, mem_rq, sec_rq, mwi_rq, err_rq} = 5'h1f;
		@(posedge clk);
		#1;
		{io_rq, mem_rq, sec_rq, mwi_rq, err_rq} = 5'h00;
		check("gate", {26'h0, io_ac, mem_ac, sec_ac, mst, mwi, err_s},
			{26'h0, c[0], c[1], c[2], c[2], c[2], c[8]});
	endtask

	task automatic poison(input logic c, input logic w);
		@(posedge clk);
		#1;
		{pois_c, pois_w} = {c, w};
		@(posedge clk);
		#1;
		{pois_c, pois_w} = 2'h0;
	endtask

	task automatic rd_chk(input string nm, input bcr_addr_t a,
		input logic [31:0] exp);
		rc.cfg_read(a, d, v);
		check("rvalid", {31'h0, v}, 32'h1);
		check(nm, d, exp);
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			end_of_test();
		end
	end

	initial
	begin
		{rst, ce} = 2'h3;
		{io_rq, mem_rq, sec_rq, mwi_rq, err_rq, pois_c, pois_w} = 7'h00;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'h0;
		rd_chk("cmd reset", BCR_CMD_OFF, 32'h0);
		pulse_reqs(16'h0000);
		$display("test reset done");
		rc.cfg_write(BCR_CMD_OFF, 32'h0000_ffff, 4'hf);
		rd_chk("cmd mask", BCR_CMD_OFF, 32'h0000_0567);
		pulse_reqs(16'h0567);
		rc.cfg_write(BCR_CMD_OFF, 32'h0, 4'h2);
		rd_chk("byte lane", BCR_CMD_OFF, 32'h0000_0067);
		rc.cfg_write(8'h08, 32'h0, 4'hf);
		rd_chk("unmapped", 8'h08, 32'h0);
		rd_chk("unchanged", BCR_CMD_OFF, 32'h0000_0067);
		$display("test access done");
		for (int i = 0; i < 4; i++)
		begin
			rc.cfg_write(BCR_CMD_OFF, 32'h1 << sel[i], 4'hf);
			pulse_reqs(16'h1 << sel[i]);
		end
		$display("test gate done");
		rc.cfg_write(BCR_CMD_OFF, 32'h0, 4'hf);
		poison(1'h1, 1'h1);
		rd_chk("flag off", BCR_CMD_OFF, 32'h0);
		rc.cfg_write(BCR_CMD_OFF, 32'h40, 4'hf);
		poison(1'h1, 1'h0);
		rd_chk("flag cpl", BCR_CMD_OFF, 32'h0100_0040);
		check("mdpe", {31'h0, mdpe}, 32'h1);
		rc.cfg_write(BCR_CMD_OFF, 32'h0100_0040, 4'h9);
		rd_chk("flag clr", BCR_CMD_OFF, 32'h0000_0040);
		poison(1'h0, 1'h1);
		rd_chk("flag wr", BCR_CMD_OFF, 32'h0100_0040);
		$display("test parity done");
		// With the enable low, requests and a write must leave all as it was.
		rc.cfg_write(BCR_CMD_OFF, 32'h0000_0105, 4'hf);
		@(posedge clk);
		#1;
		ce = 1'h0;
		{io_rq, mem_rq, sec_rq, mwi_rq, err_rq} = 5'h1f;
		rc.cfg_write(BCR_CMD_OFF, 32'h0100_0000, 4'hf);
		check("frozen", {25'h0, io_ac, mem_ac, sec_ac, mst, mwi, err_s, mdpe},
			32'h0000_0009);
		@(posedge clk);
		#1;
		ce = 1'h1;
		{io_rq, mem_rq, sec_rq, mwi_rq, err_rq} = 5'h00;
		rd_chk("frozen cmd", BCR_CMD_OFF, 32'h0100_0105);
		$display("test enable done");
		// A reset in mid-run clears the command, the flag and the decisions.
		@(posedge clk);
		#1;
		rst = 1'h1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'h0;
		check("rst outs", {25'h0, io_ac, mem_ac, sec_ac, mst, mwi, err_s, mdpe},
			32'h0);
		rd_chk("cmd rerst", BCR_CMD_OFF, 32'h0);
		$display("test reset again done");
		end_of_test();
	end

endmodule // bcr_cmd_reg_tb_top

`default_nettype wire
